// file: verilog/earth_fault_consts.svh
// Constants for the residual overcurrent stage: register offsets, field positions,
// reset values and timing counts. Assumes a 40 MHz clock and a 5 ms sample strobe.
`ifndef EARTH_FAULT_CONSTS_SVH
`define EARTH_FAULT_CONSTS_SVH
// Register byte offsets.
`define OFS_CONTROL 8'h00
`define OFS_THRESHOLD 8'h04
`define OFS_BUS_THRESHOLD 8'h08
`define OFS_STATUS 8'h0C
`define OFS_RATIO 8'h10
`define OFS_ANGLE 8'h14
`define OFS_EXPECTED 8'h18
`define OFS_REMAINING 8'h1C
`define OFS_CNT_START 8'h20
`define OFS_CNT_TRIP 8'h24
`define OFS_CNT_BLOCK 8'h28
`define OFS_CNT_CLEAR 8'h2C
// Control field positions.
`define CTL_SRC_LSB 0
`define CTL_MAG_LSB 2
`define CTL_MODE_LSB 4
`define CTL_FORCE_LSB 7
`define CTL_PERMIT_BIT 9
`define CTL_MODE_EN_BIT 10
`define CTL_FORCE_EN_BIT 11
// Reset values: threshold in steps of 0.0001 nominal, 1.20 nominal.
`define THRESHOLD_RESET 24'h00_2EE0
`define CONTROL_RESET 12'h000
// Release ratio in percent and ratio scale of 0.01.
`define RELEASE_PCT 8'h61
`define RATIO_SCALE 8'h64
// Timing: sample period in ms and remaining-time cap in 5 ms ticks (1800 s).
`define SAMPLE_MS 5
`define MAX_TIME_TICKS 20'h5_7E40
`endif

// file: verilog/earth_fault_pkg.sv
// Types for the residual overcurrent stage.
// Assumes the constants header is included by users of these types.
package earth_fault_pkg;
  // Residual source choice.
  typedef enum logic [1:0] {SRC_COARSE = 2'h0, SRC_SENSITIVE = 2'h1, SRC_DERIVED = 2'h2} src_t;
  // Magnitude kind for measured inputs.
  typedef enum logic [1:0] {MAG_FUND = 2'h0, MAG_TRUE = 2'h1, MAG_PEAK = 2'h2} mag_t;
  // Operating mode, shared by setting and report.
  typedef enum logic [2:0] {
    MODE_ON = 3'h0, MODE_BLOCKED = 3'h1, MODE_TEST = 3'h2, MODE_TEST_BLOCKED = 3'h3,
    MODE_OFF = 3'h4
  } mode_t;
  // Reported condition.
  typedef enum logic [1:0] {COND_NORMAL = 2'h0, COND_START = 2'h1, COND_TRIP = 2'h2,
    COND_BLOCKED = 2'h3} cond_t;
  // Stage state, Gray coded along idle, start, trip.
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_START = 2'h1, ST_TRIP = 2'h3,
    ST_BLOCKED = 2'h2} state_t;
  // All residual magnitudes, steps of 0.0001 nominal.
  typedef struct packed {
    logic [23:0] coarse_fund;
    logic [23:0] coarse_true;
    logic [23:0] coarse_peak;
    logic [23:0] sens_fund;
    logic [23:0] sens_true;
    logic [23:0] sens_peak;
    logic [23:0] derived;
  } meas_t;
  // One-cycle event pulses.
  typedef struct packed {
    logic start_on;
    logic start_off;
    logic trip_on;
    logic trip_off;
    logic block_on;
    logic block_off;
  } events_t;
endpackage : earth_fault_pkg

// file: verilog/earth_fault_stage.sv
// Residual overcurrent stage: source selection, pick-up with release band,
// blocking, modes, forcing, timing report, events and counters.
// Assumes a front end delivering all magnitudes with a 5 ms sample strobe,
// and an external delay curve supplying the operating time in 5 ms ticks.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "earth_fault_consts.svh"

module earth_fault_stage (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic sample_in,
  input wire earth_fault_pkg::meas_t meas_in,
  input wire logic signed [15:0] angle_in,
  input wire logic [1:0] phase_in,
  input wire logic forward_in,
  input wire logic [19:0] op_time_in,
  input wire logic block_in,
  output logic [31:0] rdata_out,
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output earth_fault_pkg::cond_t cond_out,
  output earth_fault_pkg::events_t events_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Settings.

  logic [11:0] control; // Static settings word.
  logic [23:0] threshold; // Pick-up threshold, one value for all phases.
  earth_fault_pkg::src_t src;
  earth_fault_pkg::mag_t mag;
  earth_fault_pkg::mode_t mode_set;
  earth_fault_pkg::cond_t force_set;
  logic permit;
  logic mode_en;
  logic force_en;

  assign src = earth_fault_pkg::src_t'(control[`CTL_SRC_LSB +: 2]);
  assign mag = earth_fault_pkg::mag_t'(control[`CTL_MAG_LSB +: 2]);
  assign mode_set = earth_fault_pkg::mode_t'(control[`CTL_MODE_LSB +: 3]);
  assign force_set = earth_fault_pkg::cond_t'(control[`CTL_FORCE_LSB +: 2]);
  assign permit = control[`CTL_PERMIT_BIT];
  assign mode_en = control[`CTL_MODE_EN_BIT];
  assign force_en = control[`CTL_FORCE_EN_BIT];

  // Control register: reset gives coarse source, fundamental, mode on, no forcing.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      control <= `CONTROL_RESET;
    end else if (wr_in && addr_in == `OFS_CONTROL) begin
      control <= wdata_in[11:0];
    end
  end

  // Threshold takes effect at the next sample; the stage keeps running.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      threshold <= `THRESHOLD_RESET;
    end else if (wr_in && addr_in == `OFS_THRESHOLD) begin
      threshold <= wdata_in[23:0];
    end else if (wr_in && addr_in == `OFS_BUS_THRESHOLD && permit) begin
      threshold <= wdata_in[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective mode and selected magnitude.

  earth_fault_pkg::mode_t mode_eff;
  logic [23:0] level; // Selected magnitude.
  logic over; // Above threshold.
  logic under; // Below release level.

  // The mode setting only counts when individual mode setting is enabled.
  always_comb begin
    mode_eff = mode_en ? mode_set : earth_fault_pkg::MODE_ON;
  end

  // Pick one source; the magnitude kind applies to measured inputs only.
  always_comb begin
    level = meas_in.coarse_fund;
    if (src == earth_fault_pkg::SRC_DERIVED) begin
      level = meas_in.derived;
    end else if (src == earth_fault_pkg::SRC_SENSITIVE) begin
      level = (mag == earth_fault_pkg::MAG_PEAK) ? meas_in.sens_peak :
              (mag == earth_fault_pkg::MAG_TRUE) ? meas_in.sens_true : meas_in.sens_fund;
    end else begin
      // True RMS arrives already summed over 32 harmonics.
      level = (mag == earth_fault_pkg::MAG_PEAK) ? meas_in.coarse_peak :
              (mag == earth_fault_pkg::MAG_TRUE) ? meas_in.coarse_true : meas_in.coarse_fund;
    end
  end

  // Release compares 100 x level against 97 x threshold, avoiding a division.
  always_comb begin
    over = level > threshold;
    under = (32'(level) * 32'(`RATIO_SCALE)) < (32'(threshold) * 32'(`RELEASE_PCT));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage state machine, stepped once per 5 ms sample.

  earth_fault_pkg::state_t state;
  earth_fault_pkg::state_t next_state;
  logic [19:0] remaining; // Ticks of 5 ms left before trip.
  logic [19:0] op_clamped;
  logic inactive;

  assign op_clamped = (op_time_in > `MAX_TIME_TICKS) ? `MAX_TIME_TICKS : op_time_in;
  assign inactive = mode_eff == earth_fault_pkg::MODE_OFF;

  // Block is looked at only on the sample strobe, which starts each cycle.
  always_comb begin
    next_state = state;
    case (state)
      earth_fault_pkg::ST_IDLE: begin
        if (over) begin
          next_state = block_in ? earth_fault_pkg::ST_BLOCKED : earth_fault_pkg::ST_START;
        end
      end
      earth_fault_pkg::ST_START: begin
        if (block_in) begin
          next_state = earth_fault_pkg::ST_BLOCKED;
        end else if (under) begin
          next_state = earth_fault_pkg::ST_IDLE;
        end else if (remaining <= 20'h0_0001) begin
          next_state = earth_fault_pkg::ST_TRIP;
        end
      end
      earth_fault_pkg::ST_TRIP: begin
        if (under) begin
          next_state = earth_fault_pkg::ST_IDLE;
        end
      end
      default: begin
        // Blocked: no further processing until the current falls away or the block drops.
        if (under || !block_in) begin
          next_state = earth_fault_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // State advances on every new sample only; mode off holds it idle at once.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || inactive) begin
      state <= earth_fault_pkg::ST_IDLE;
    end else if (sample_in) begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing report.

  logic [19:0] expected; // Expected operating time, 5 ms ticks.

  // Expected time follows the curve on every sample so inverse time tracks the current.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      expected <= 20'h0_0000;
    end else if (sample_in) begin
      expected <= op_clamped;
    end
  end

  // Remaining time loads at start and counts down one tick per sample.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      remaining <= 20'h0_0000;
    end else if (sample_in) begin
      if (state == earth_fault_pkg::ST_IDLE && next_state == earth_fault_pkg::ST_START) begin
        remaining <= op_clamped;
      end else if (state == earth_fault_pkg::ST_START &&
                   next_state == earth_fault_pkg::ST_START) begin
        remaining <= remaining - 20'h0_0001;
      end else if (next_state != earth_fault_pkg::ST_START) begin
        remaining <= 20'h0_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ratio of level to threshold in steps of 0.01, by a serial divider.
  // A divider of 32 cycles is far cheaper than a wide one and 5 ms is plenty.

  logic [31:0] quot;
  logic [31:0] rem;
  logic [5:0] div_cnt;
  logic [15:0] ratio; // Published ratio.
  logic [32:0] trial;

  assign trial = {rem, quot[31]} - {9'h000, threshold};

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      quot <= 32'h0000_0000;
      rem <= 32'h0000_0000;
      div_cnt <= 6'h00;
    end else if (sample_in) begin
      quot <= 32'(level) * 32'(`RATIO_SCALE);
      rem <= 32'h0000_0000;
      div_cnt <= 6'h20;
    end else if (div_cnt != 6'h00) begin
      if (!trial[32]) begin
        rem <= trial[31:0];
        quot <= {quot[30:0], 1'b1};
      end else begin
        rem <= {rem[30:0], quot[31]};
        quot <= {quot[30:0], 1'b0};
      end
      div_cnt <= div_cnt - 6'h01;
    end
  end

  // Publish on completion; a zero threshold saturates. In the last step quot still
  // carries one dividend bit on top, so the overflow test looks at bits 30 to 15.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ratio <= 16'h0000;
    end else if (div_cnt == 6'h01) begin
      ratio <= (threshold == 24'h00_0000 || |quot[30:15]) ?
               16'hFFFF : {quot[14:0], !trial[32]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Angle latched on every sample; fault type latched when a fault is picked up.

  logic signed [15:0] angle; // Steps of 0.01 degree.
  logic [2:0] fault_type; // 0 none, 1..6 phase and direction.

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      angle <= 16'sh0000;
    end else if (sample_in) begin
      angle <= angle_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fault_type <= 3'h0;
    end else if (sample_in && state == earth_fault_pkg::ST_IDLE &&
                 next_state == earth_fault_pkg::ST_START) begin
      case ({phase_in, forward_in})
        3'b000: fault_type <= 3'h1; // A reverse.
        3'b011: fault_type <= 3'h2; // B forward.
        3'b100: fault_type <= 3'h3; // C reverse.
        3'b001: fault_type <= 3'h4; // A forward.
        3'b010: fault_type <= 3'h5; // B reverse.
        default: fault_type <= 3'h6; // C forward.
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reported condition, outputs and events.

  earth_fault_pkg::cond_t cond_raw;
  earth_fault_pkg::cond_t cond_rep;
  logic test_mode;

  assign test_mode = mode_eff == earth_fault_pkg::MODE_TEST ||
                     mode_eff == earth_fault_pkg::MODE_TEST_BLOCKED;

  // Blocked modes override; forcing overrides everything when enabled.
  always_comb begin
    case (state)
      earth_fault_pkg::ST_START: cond_raw = earth_fault_pkg::COND_START;
      earth_fault_pkg::ST_TRIP: cond_raw = earth_fault_pkg::COND_TRIP;
      earth_fault_pkg::ST_BLOCKED: cond_raw = earth_fault_pkg::COND_BLOCKED;
      default: cond_raw = earth_fault_pkg::COND_NORMAL;
    endcase
    if (mode_eff == earth_fault_pkg::MODE_BLOCKED ||
        mode_eff == earth_fault_pkg::MODE_TEST_BLOCKED) begin
      cond_raw = earth_fault_pkg::COND_BLOCKED;
    end
    cond_rep = force_en ? force_set : cond_raw;
  end

  // Test modes report the condition but keep the start and trip outputs quiet.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cond_out <= earth_fault_pkg::COND_NORMAL;
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
    end else begin
      cond_out <= cond_rep;
      start_out <= !test_mode && cond_rep == earth_fault_pkg::COND_START;
      trip_out <= !test_mode && cond_rep == earth_fault_pkg::COND_TRIP;
      blocked_out <= cond_rep == earth_fault_pkg::COND_BLOCKED;
    end
  end

  // Events are edges of the reported condition, one cycle wide.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      events_out <= '0;
    end else begin
      events_out.start_on <= cond_rep == earth_fault_pkg::COND_START &&
                             cond_out != earth_fault_pkg::COND_START;
      events_out.start_off <= cond_rep != earth_fault_pkg::COND_START &&
                              cond_out == earth_fault_pkg::COND_START;
      events_out.trip_on <= cond_rep == earth_fault_pkg::COND_TRIP &&
                            cond_out != earth_fault_pkg::COND_TRIP;
      events_out.trip_off <= cond_rep != earth_fault_pkg::COND_TRIP &&
                             cond_out == earth_fault_pkg::COND_TRIP;
      events_out.block_on <= cond_rep == earth_fault_pkg::COND_BLOCKED &&
                             cond_out != earth_fault_pkg::COND_BLOCKED;
      events_out.block_off <= cond_rep != earth_fault_pkg::COND_BLOCKED &&
                              cond_out == earth_fault_pkg::COND_BLOCKED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cumulative counters; an event in the clearing cycle still counts.

  logic [15:0] counts [3];
  logic [2:0] count_hit;
  logic [2:0] count_clr;

  assign count_hit = {events_out.block_on, events_out.trip_on, events_out.start_on};
  assign count_clr = (wr_in && addr_in == `OFS_CNT_CLEAR) ? wdata_in[2:0] : 3'h0;

  for (genvar i = 0; i < 3; i++) begin : g_count
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        counts[i] <= 16'h0000;
      end else if (count_clr[i]) begin
        counts[i] <= {15'h0000, count_hit[i]};
      end else if (count_hit[i] && counts[i] != 16'hFFFF) begin
        counts[i] <= counts[i] + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stand the cycle after the strobe; unmapped reads zero.

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !rd_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (addr_in == `OFS_CONTROL) begin
      rdata_out <= {20'h0_0000, control};
    end else if (addr_in == `OFS_THRESHOLD || addr_in == `OFS_BUS_THRESHOLD) begin
      rdata_out <= {8'h00, threshold};
    end else if (addr_in == `OFS_STATUS) begin
      rdata_out <= {24'h00_0000, fault_type, mode_eff, cond_rep};
    end else if (addr_in == `OFS_RATIO) begin
      rdata_out <= {16'h0000, ratio};
    end else if (addr_in == `OFS_ANGLE) begin
      rdata_out <= {{16{angle[15]}}, angle};
    end else if (addr_in == `OFS_EXPECTED) begin
      rdata_out <= {12'h000, expected};
    end else if (addr_in == `OFS_REMAINING) begin
      rdata_out <= {12'h000, remaining};
    end else if (addr_in == `OFS_CNT_START) begin
      rdata_out <= {16'h0000, counts[0]};
    end else if (addr_in == `OFS_CNT_TRIP) begin
      rdata_out <= {16'h0000, counts[1]};
    end else if (addr_in == `OFS_CNT_BLOCK) begin
      rdata_out <= {16'h0000, counts[2]};
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

endmodule : earth_fault_stage

// file: test/earth_fault_checker.sv
// Checker: assertions on the residual stage outputs.
// Assumes it is bound to the stage and sees only its ports.
`timescale 1ns/1ps
module earth_fault_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_in,
  input wire logic sample_in,
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic blocked_out,
  input wire earth_fault_pkg::cond_t cond_out,
  input wire earth_fault_pkg::events_t events_out
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Decoded condition, to keep the properties short.
  wire c_start = (cond_out == earth_fault_pkg::COND_START);
  wire c_trip = (cond_out == earth_fault_pkg::COND_TRIP);
  wire c_block = (cond_out == earth_fault_pkg::COND_BLOCKED);
  ////////////////////////////////////////
  // Output levels must agree with the reported condition.
  start_level_a: assert property (start_out |-> c_start)
    else $error("start level outside start");
  trip_level_a: assert property (trip_out |-> c_trip)
    else $error("trip level outside trip");
  blocked_level_a: assert property (blocked_out |-> c_block)
    else $error("blocked level outside blocked");
  // A sample moves the condition two edges later; a write may also move it.
  cond_cause_a: assert property ($changed(cond_out) |->
      $past(sample_in, 2) || $past(wr_in, 2) || $past(wr_in, 3))
    else $error("condition moved without a cause");
  // Events mark the edges of the condition in the same cycle.
  start_event_a: assert property ($rose(c_start) |-> events_out.start_on)
    else $error("start entry without start event");
  trip_release_a: assert property ($fell(c_trip) |-> events_out.trip_off)
    else $error("trip exit without trip event");
  block_event_a: assert property (events_out.block_on |-> c_block && $changed(cond_out))
    else $error("block event without block entry");
  event_pulse_a: assert property (events_out.trip_on |=> !events_out.trip_on)
    else $error("trip event longer than a cycle");
  cover property (events_out.start_on);
  cover property (events_out.trip_on);
  cover property (events_out.block_on);
endmodule : earth_fault_checker

// file: test/residual_front_end.sv
// Model of the analog front end that feeds one magnitude sample set.
// Assumes the bench pulses go_in once per sample it wants delivered.
`timescale 1ns/1ps
module residual_front_end (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic go_in,
  input wire earth_fault_pkg::meas_t meas_in,
  input wire logic [19:0] op_time_in,
  output logic sample_out,
  output earth_fault_pkg::meas_t meas_out,
  output logic [19:0] op_time_out
);
  // Values latched for the next strobe.
  earth_fault_pkg::meas_t held;
  logic [19:0] held_op;
  // The strobe stands for the refresh; spacing is shortened from 5 ms.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sample_out <= 1'b0;
      held <= '0;
      held_op <= 20'h0_0000;
    end else begin
      sample_out <= go_in;
      if (go_in) begin
        held <= meas_in;
        held_op <= op_time_in;
      end
    end
  end
  // Outside the strobe the bus carries garbage, so stale data cannot pass.
  assign meas_out = sample_out ? held : ~held;
  assign op_time_out = sample_out ? held_op : ~held_op;
endmodule : residual_front_end

// file: test/testbench.sv
// Self-checking bench for the residual overcurrent stage.
// Assumes the stage, its package and the front end model are compiled first.
`timescale 1ns/1ps
module testbench;
  localparam int GAP = 40; // Cycles after a sample; the ratio needs 33.
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic go = 1'b0;
  logic sample_in;
  earth_fault_pkg::meas_t meas_req = '0;
  earth_fault_pkg::meas_t meas_in;
  logic signed [15:0] angle_in = 16'h0000;
  logic [1:0] phase_in = 2'h0;
  logic forward_in = 1'b0;
  logic [19:0] op_time_in;
  logic block_in = 1'b0;
  logic [31:0] rdata_out;
  logic start_out;
  logic trip_out;
  logic blocked_out;
  earth_fault_pkg::cond_t cond_out;
  earth_fault_pkg::events_t events_out;
  // Bench model state: condition, ticks left, threshold, control word.
  int bad_count = 0;
  int checked = 0;
  int st = 0;
  int rem = 0;
  int thr = 12000;
  int k;
  logic [31:0] ctl = 32'h0000_0000;
  logic [31:0] v;
  logic [15:0] ang = 16'h0000;
  logic [1:0] ph = 2'h0;
  logic fw = 1'b0;
  logic blk = 1'b0;
  logic [19:0] opt = 20'h0_0003; // Operating time handed to the front end.
  always #12.5 clk_in = ~clk_in;
  earth_fault_stage dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .sample_in(sample_in),
    .meas_in(meas_in), .angle_in(angle_in), .phase_in(phase_in), .forward_in(forward_in),
    .op_time_in(op_time_in), .block_in(block_in), .rdata_out(rdata_out),
    .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
    .cond_out(cond_out), .events_out(events_out));
  residual_front_end fe_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go),
    .meas_in(meas_req), .op_time_in(opt), .sample_out(sample_in),
    .meas_out(meas_in), .op_time_out(op_time_in));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    v = rdata_out;
    @(posedge clk_in);
    if (exp !== 32'hFFFF_FFFF) check(v, exp);
  endtask : rdc
  task automatic set_ctl(input logic [31:0] d);
    ctl = d;
    wr(8'h00, d);
  endtask : set_ctl
  function automatic int sel(input earth_fault_pkg::meas_t m);
    logic [23:0] f;
    f = (ctl[3:2] == 2'h1) ? m.coarse_true : (ctl[3:2] == 2'h2) ? m.coarse_peak : m.coarse_fund;
    if (ctl[1:0] == 2'h1) begin
      f = (ctl[3:2] == 2'h1) ? m.sens_true : (ctl[3:2] == 2'h2) ? m.sens_peak : m.sens_fund;
    end
    return (ctl[1:0] == 2'h2) ? m.derived : f;
  endfunction : sel
  function automatic logic [2:0] ftype(input logic [1:0] p, input logic f);
    case (p)
      2'h0: return f ? 3'h4 : 3'h1;
      2'h1: return f ? 3'h2 : 3'h5;
      default: return f ? 3'h6 : 3'h3;
    endcase
  endfunction : ftype
  // Model steps first, then one sample goes out and the condition is compared.
  task automatic smp();
    int m;
    m = sel(meas_req);
    if (ctl[10] && ctl[6:4] == 3'h4) st = 0;
    else if (st == 0) begin
      if (m > thr) begin
        st = blk ? 3 : 1;
        rem = (opt > 360000) ? 360000 : opt;
      end
    end else if (st == 1 && blk) st = 3;
    else if (100 * m < 97 * thr) st = 0;
    else if (st == 3 && !blk) st = 0;
    else if (st == 1) begin
      if (rem <= 1) st = 2;
      else rem--;
    end
    block_in <= blk;
    angle_in <= ang;
    phase_in <= ph;
    forward_in <= fw;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (GAP) @(posedge clk_in);
    check(cond_out, st);
    check({blocked_out, trip_out, start_out}, (st == 0) ? 0 : 1 << (st - 1));
  endtask : smp
  task automatic final_report();
    $display("TB: checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (100000) @(posedge clk_in);
    bad_count++;
    final_report();
  end
  ////////////////////////////////////////
  initial begin
    v = $urandom(32180);
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h04, 32'h0000_2EE0);
    // Bus threshold refused without permission, then accepted while running.
    wr(8'h08, 32'h0000_01F4);
    meas_req.coarse_fund = 24'd800;
    smp();
    set_ctl(32'h0000_0200);
    wr(8'h08, 32'h0000_03E8);
    thr = 1000;
    for (int i = 0; i < 4; i++) begin
      meas_req.coarse_fund = (i == 0) ? 1000 : (i == 1) ? 1001 : (i == 2) ? 970 : 969;
      smp();
      if (i == 1) rdc(8'h1C, rem);
    end
    // Count down to trip, then release.
    meas_req.coarse_fund = 24'd2000;
    repeat (4) smp();
    rdc(8'h18, 32'h0000_0003);
    rdc(8'h10, 32'h0000_00C8);
    meas_req.coarse_fund = 24'd0;
    smp();
    rdc(8'h20, 32'h0000_0002);
    rdc(8'h24, 32'h0000_0001);
    wr(8'h2C, 32'h0000_0007);
    rdc(8'h20, 32'h0000_0000);
    // Blocked pick-up.
    blk = 1'b1;
    meas_req.coarse_fund = 24'd2000;
    smp();
    rdc(8'h28, 32'h0000_0001);
    meas_req.coarse_fund = 24'd0;
    smp();
    blk = 1'b0;
    // A block arriving while the delay still runs keeps the trip away; its drop releases.
    opt = 20'hF_FFFF;
    meas_req.coarse_fund = 24'd2000;
    smp();
    rdc(8'h18, 32'h0005_7E40);
    rdc(8'h1C, 32'h0005_7E40);
    blk = 1'b1;
    repeat (3) smp();
    rdc(8'h24, 32'h0000_0000);
    rdc(8'h28, 32'h0000_0002);
    blk = 1'b0;
    smp();
    // Every source and magnitude kind, with random angle and fault phase.
    for (int s = 0; s < 3; s++) begin
      for (int g = 0; g < 3; g++) begin
        set_ctl(32'h0000_0200 | (g << 2) | s);
        k = (s < 2) ? s * 3 + g : 6;
        ang = 16'($urandom);
        ph = 2'($urandom_range(2));
        fw = 1'($urandom);
        meas_req = {7{24'd500}};
        meas_req[167 - 24 * k -: 24] = 24'd2000;
        smp();
        meas_req = {7{24'd2000}};
        meas_req[167 - 24 * k -: 24] = 24'd500;
        smp();
        rdc(8'h0C, 32'hFFFF_FFFF);
        check(v[7:2], {ftype(ph, fw), 3'h0});
        rdc(8'h14, 32'hFFFF_FFFF);
        check(v[15:0], ang);
      end
    end
    // Mode without its enable stays on; every mode when enabled.
    set_ctl(32'h0000_0040);
    rdc(8'h0C, 32'hFFFF_FFFF);
    check(v[4:2], 3'h0);
    for (int m = 0; m < 5; m++) begin
      set_ctl(32'h0000_0400 | (m << 4));
      rdc(8'h0C, 32'hFFFF_FFFF);
      check(v[4:2], m);
    end
    meas_req = {7{24'd2000}};
    smp();
    // Every forced status.
    for (int f = 0; f < 4; f++) begin
      set_ctl(32'h0000_0800 | (f << 7));
      repeat (2) @(posedge clk_in);
      check(cond_out, f);
    end
    set_ctl(32'h0000_0180);
    repeat (2) @(posedge clk_in);
    check(cond_out, 0);
    final_report();
  end
endmodule : testbench
bind earth_fault_stage earth_fault_checker chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .wr_in(wr_in), .sample_in(sample_in), .start_out(start_out), .trip_out(trip_out),
  .blocked_out(blocked_out), .cond_out(cond_out), .events_out(events_out));
